// *** inc/option_byte_consts.vh ***
// Constants for the static option byte configuration block.
// Assumes a single 25 MHz clock and a synchronous active-high reset.
// Functional notes
// - Option bytes unmapped; accessible only in programming mode.
// - Unprogrammed option storage reads all ones.
// - Bit 7 set: halt entry with watchdog resets.
// - Bit 6 clear: watchdog forced on in hardware.
// - Bits 4:3 select detector threshold or off.
// - Bit 0 clear: block readout and flash writes.
// - Protected option erase wipes user memory first.
`ifndef OPTION_BYTE_CONSTS_VH
`define OPTION_BYTE_CONSTS_VH
`define OPT_ERASED 8'hff
`define OPT0_DEFAULT 8'he7
`define OPT1_DEFAULT 8'hef
`define OPT0_RSVD_MASK 8'h26
`define OPT_HALT_RST_BIT 7
`define OPT_WDOG_SOFT_BIT 6
`define OPT_DET_HI_BIT 4
`define OPT_DET_LO_BIT 3
`define OPT_RDP_BIT 0
`define DET_OFF 2'h3
`define DET_LOW 2'h2
`define DET_MED 2'h1
`define DET_HIGH 2'h0
`define STATE_IDLE 2'h0
`define STATE_WIPE 2'h1
`define STATE_CLEAR 2'h2
`endif

// *** rtl/option_byte_config.v ***
// Option byte storage, programming access and static configuration outputs.
// Assumes a programming tool drives the prog_* ports only in programming mode.
`include "option_byte_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module option_byte_config (
	input wire mclk_in,
	input wire srst_in,
	input wire prog_mode_in,
	input wire prog_sel_in,
	input wire prog_write_in,
	input wire prog_erase_in,
	input wire [7:0] prog_wdata_in,
	input wire user_wipe_done_in,
	input wire halt_entry_in,
	input wire watchdog_active_in,
	output reg [7:0] prog_rdata_out,
	output wire prog_busy_out,
	output reg user_wipe_req_out,
	output reg watchdog_reset_on_halt_out,
	output reg watchdog_software_select_out,
	output reg [1:0] voltage_detect_threshold_select_out,
	output reg low_voltage_reset_detector_en_out,
	output reg voltage_warning_detector_en_out,
	output reg readout_protection_select_out,
	output reg [7:0] option1_out,
	output wire watchdog_forced_on_out,
	output wire halt_reset_req_out,
	output wire flash_write_block_out,
	output wire readout_block_out
);
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg erase_pend_reg;
	reg [7:0] readback_next;
	wire [7:0] opt0;
	wire [7:0] opt1;
	wire [7:0] prog0_data;
	wire [1:0] det_code;
	wire det_enable;
	wire access_ok;
	wire erase_cells;
	wire prog0;
	wire prog1;

	// No memory-map path exists; only the programming port reaches the cells
	assign access_ok = prog_mode_in && (state_reg == `STATE_IDLE);

	// Reserved bits forced to default so a careless tool cannot upset them
	assign prog0_data = prog_wdata_in | `OPT0_RSVD_MASK;
	assign prog0 = access_ok && prog_write_in && !prog_sel_in;
	assign prog1 = access_ok && prog_write_in && prog_sel_in;
	assign erase_cells = (state_reg == `STATE_CLEAR);

	option_cell #(
		.INIT(`OPT0_DEFAULT)
	) cell0 (
		.mclk_in(mclk_in),
		.erase_in(erase_cells),
		.prog_in(prog0),
		.data_in(prog0_data),
		.value_out(opt0)
	);

	option_cell #(
		.INIT(`OPT1_DEFAULT)
	) cell1 (
		.mclk_in(mclk_in),
		.erase_in(erase_cells),
		.prog_in(prog1),
		.data_in(prog_wdata_in),
		.value_out(opt1)
	);

	// Erase of protected options must wipe user memory before the bytes clear
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			`STATE_IDLE:
			begin
				if (access_ok && prog_erase_in)
				begin
					if (!opt0[`OPT_RDP_BIT])
					begin
						state_next = `STATE_WIPE;
					end
					else
					begin
						state_next = `STATE_CLEAR;
					end
				end
			end
			`STATE_WIPE:
			begin
				if (user_wipe_done_in)
				begin
					state_next = `STATE_CLEAR;
				end
			end
			`STATE_CLEAR:
			begin
				state_next = `STATE_IDLE;
			end
			default:
			begin
				state_next = `STATE_IDLE;
			end
		endcase
	end

	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			state_reg <= `STATE_IDLE;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Busy follows the next state so it rises on the edge that takes the erase
	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			erase_pend_reg <= 1'b0;
		end
		else
		begin
			erase_pend_reg <= (state_next != `STATE_IDLE);
		end
	end

	assign prog_busy_out = erase_pend_reg;

	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			user_wipe_req_out <= 1'b0;
		end
		else
		begin
			user_wipe_req_out <= (state_next == `STATE_WIPE);
		end
	end

	// Read-back is zero outside programming mode so nothing leaks
	always @*
	begin
		readback_next = 8'h00;
		if (access_ok)
		begin
			if (prog_sel_in)
			begin
				readback_next = opt1;
			end
			else
			begin
				readback_next = opt0;
			end
		end
	end

	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			prog_rdata_out <= 8'h00;
		end
		else
		begin
			prog_rdata_out <= readback_next;
		end
	end

	// Configuration latched only in reset, so later programming waits for a reset
	assign det_code = opt0[`OPT_DET_HI_BIT:`OPT_DET_LO_BIT];
	assign det_enable = (det_code != `DET_OFF);

	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			watchdog_reset_on_halt_out <= opt0[`OPT_HALT_RST_BIT];
		end
	end

	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			watchdog_software_select_out <= opt0[`OPT_WDOG_SOFT_BIT];
		end
	end

	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			voltage_detect_threshold_select_out <= det_code;
		end
	end

	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			low_voltage_reset_detector_en_out <= det_enable;
		end
	end

	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			voltage_warning_detector_en_out <= det_enable;
		end
	end

	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			readout_protection_select_out <= opt0[`OPT_RDP_BIT];
		end
	end

	// Byte 1 fields have no decoded meaning here, so they pass through raw
	always @(posedge mclk_in)
	begin
		if (srst_in)
		begin
			option1_out <= opt1;
		end
	end

	assign watchdog_forced_on_out = !watchdog_software_select_out;
	assign halt_reset_req_out = watchdog_reset_on_halt_out && watchdog_active_in && halt_entry_in;
	assign flash_write_block_out = !readout_protection_select_out;
	assign readout_block_out = !readout_protection_select_out;
endmodule // option_byte_config
`default_nettype wire

// *** rtl/option_cell.v ***
// One non-volatile option byte cell with erase and program.
// Assumes the caller gates access with programming mode.
`include "option_byte_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module option_cell #(
	parameter [7:0] INIT = 8'hff
)(
	input wire mclk_in,
	input wire erase_in,
	input wire prog_in,
	input wire [7:0] data_in,
	output wire [7:0] value_out
);
	reg [7:0] cell_reg = INIT;
	// Flash programming can only clear bits; erase returns to all ones
	always @(posedge mclk_in)
	begin
		if (erase_in)
			cell_reg <= `OPT_ERASED;
		else if (prog_in)
			cell_reg <= cell_reg & data_in;
	end
	assign value_out = cell_reg;
endmodule // option_cell
`default_nettype wire

// *** test/option_byte_props.sv ***
// Checker on the option byte block ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module option_byte_props (
	input wire logic mclk_in,
	input wire logic srst_in,
	input wire logic prog_mode_in,
	input wire logic user_wipe_done_in,
	input wire logic halt_entry_in,
	input wire logic watchdog_active_in,
	input wire logic prog_busy_out,
	input wire logic user_wipe_req_out,
	input wire logic watchdog_reset_on_halt_out,
	input wire logic watchdog_software_select_out,
	input wire logic watchdog_forced_on_out,
	input wire logic halt_reset_req_out,
	input wire logic readout_protection_select_out,
	input wire logic readout_block_out,
	input wire logic flash_write_block_out,
	input wire logic low_voltage_reset_detector_en_out,
	input wire logic voltage_warning_detector_en_out,
	input wire logic [1:0] voltage_detect_threshold_select_out,
	input wire logic [7:0] prog_rdata_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (srst_in);
	sequence wiping;
		user_wipe_req_out && !user_wipe_done_in;
	endsequence
	sequence wipe_finishing;
		user_wipe_req_out && user_wipe_done_in;
	endsequence
	sequence clearing;
		!user_wipe_req_out && prog_busy_out ##1 !prog_busy_out;
	endsequence
	rdata_closed_a: assert property (!prog_mode_in || prog_busy_out |=> prog_rdata_out == 8'h00)
		else $error("read data leaked");
	rdp_block_a: assert property (readout_block_out != readout_protection_select_out)
		else $error("protection output wrong");
	wipe_wait_a: assert property (wiping |=> user_wipe_req_out && prog_busy_out)
		else $error("wipe dropped early");
	cfg_hold_a: assert property (!srst_in |=> $stable(readout_protection_select_out))
		else $error("config changed");
	wipe_end_a: assert property (wipe_finishing |=> clearing)
		else $error("erase did not follow wipe");
	forced_on_a: assert property (watchdog_forced_on_out == !watchdog_software_select_out)
		else $error("watchdog type output wrong");
	halt_req_a: assert property (halt_reset_req_out ==
		(watchdog_reset_on_halt_out && watchdog_active_in && halt_entry_in))
		else $error("halt reset request wrong");
	flash_block_a: assert property (flash_write_block_out == !readout_protection_select_out)
		else $error("write block output wrong");
	detect_enable_a: assert property (low_voltage_reset_detector_en_out ==
		(voltage_detect_threshold_select_out != 2'h3) && voltage_warning_detector_en_out == low_voltage_reset_detector_en_out)
		else $error("detector enable wrong");
endmodule // option_byte_props
bind option_byte_config option_byte_props u_props (.*);
`default_nettype wire

// *** test/tb_top.sv ***
// Bench: erases, programs and reloads the option bytes.
// Assumes the wipe model answers wipe requests.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'b0, mode = 1'b1, sel = 1'b0, wiped = 1'b0, halt = 1'b1, act = 1'b1;
	logic [2:0] go = 3'h4;
	logic [7:0] wd = 8'h00;
	wire [7:0] rq, o1;
	wire [10:0] cfg;
	wire done, busy, req;
	int errors = 0, checks = 0;
	always #20 clk = ~clk;
	always @(posedge clk) wiped <= wiped | (req & busy);
	wipe_model #(.LAT(9)) u_wipe (.mclk_in(clk), .req_in(req), .done_out(done));
	option_byte_config u_dut (.mclk_in(clk), .srst_in(go[2]), .prog_mode_in(mode), .prog_sel_in(sel),
		.prog_write_in(go[1]), .prog_erase_in(go[0]), .prog_wdata_in(wd), .user_wipe_done_in(done),
		.halt_entry_in(halt), .watchdog_active_in(act), .prog_rdata_out(rq), .prog_busy_out(busy),
		.user_wipe_req_out(req), .watchdog_reset_on_halt_out(cfg[10]), .watchdog_software_select_out(cfg[9]),
		.readout_protection_select_out(cfg[8]), .halt_reset_req_out(cfg[7]), .watchdog_forced_on_out(cfg[6]),
		.readout_block_out(cfg[5]), .flash_write_block_out(cfg[4]), .low_voltage_reset_detector_en_out(cfg[3]),
		.voltage_warning_detector_en_out(cfg[2]), .voltage_detect_threshold_select_out(cfg[1:0]), .option1_out(o1));
	task automatic chk(input logic [10:0] got, exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pulse(input logic [2:0] m);
		@(posedge clk);
		go <= m;
		@(posedge clk);
		go <= 3'h0;
		#1;
		while (busy === 1'b1)
			@(posedge clk) #1;
	endtask
	task automatic rd(input logic s, input logic [7:0] e);
		sel <= s;
		@(posedge clk) #1;
		chk({3'h0, rq}, {3'h0, e});
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		errors++;
		end_of_test;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		go <= 3'h0;
		@(posedge clk) #1;
		chk(cfg, 11'h78c);
		chk({3'h0, o1}, 11'h0ef);
		mode <= 1'b0;
		rd(1'b0, 8'h00);
		mode <= 1'b1;
		for (int i = 3; i >= 0; i--)
		begin
			pulse(3'h1);
			rd(1'b1, 8'hff);
			sel <= 1'b0;
			wd <= (i == 0) ? 8'h00 : {3'h7, i[1:0], 3'h7};
			pulse(3'h2);
			rd(1'b0, (i == 0) ? 8'h26 : {3'h7, i[1:0], 3'h7});
			pulse(3'h4);
			chk(cfg, {{4{i != 0}}, {3{i == 0}}, {2{i != 3}}, i[1:0]});
		end
		chk({10'h0, wiped}, 11'h000);
		pulse(3'h1);
		chk({10'h0, wiped}, 11'h001);
		rd(1'b0, 8'hff);
		sel <= 1'b1;
		wd <= 8'h5a;
		pulse(3'h2);
		rd(1'b1, 8'h5a);
		mode <= 1'b0;
		wd <= 8'h00;
		pulse(3'h2);
		mode <= 1'b1;
		rd(1'b1, 8'h5a);
		pulse(3'h4);
		chk({3'h0, o1}, 11'h05a);
		halt <= 1'b0;
		@(posedge clk) #1;
		chk({10'h0, cfg[7]}, 11'h000);
		halt <= 1'b1;
		act <= 1'b0;
		@(posedge clk) #1;
		chk({10'h0, cfg[7]}, 11'h000);
		act <= 1'b1;
		@(posedge clk) #1;
		chk({10'h0, cfg[7]}, 11'h001);
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire

// *** test/wipe_model.sv ***
// Partner model: user flash that answers a wipe request.
// Assumes one clock and a request held until answered.
`timescale 1ns/1ps
`default_nettype none
module wipe_model #(
	parameter int LAT = 9
)(
	input wire logic mclk_in,
	input wire logic req_in,
	output logic done_out
);
	logic [7:0] n_reg = 8'h00;
	// A slow answer shows that the block waits for the wipe
	always @(posedge mclk_in)
		n_reg <= req_in ? n_reg + 8'h01 : 8'h00;
	assign done_out = req_in && n_reg == LAT[7:0];
endmodule // wipe_model
`default_nettype wire
